/* charger_cfg_pkg.sv */
package charger_cfg_pkg;
  localparam logic [7:0] ADDR_PRECHG_TERM = 8'h03;
  localparam logic [7:0] ADDR_VOLT_TOPOFF = 8'h04;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h05;
  localparam logic [7:0] RST_PRECHG_TERM = 8'h22;
  localparam logic [7:0] RST_VOLT_TOPOFF = 8'h58;
  localparam logic [7:0] RST_TIMER_CTRL = 8'h9F;
  localparam logic [3:0] PRECHG_MAX_CODE = 4'hC;
  localparam logic [4:0] VOLT_MAX_CODE = 5'h18;
  localparam logic [1:0] TOPOFF_OFF = 2'h0;
  localparam logic [1:0] WD_OFF = 2'h0;
  localparam logic [1:0] WD_40S = 2'h1;
  localparam logic [1:0] WD_80S = 2'h2;
  localparam int CLK_HZ = 40000000;
  localparam int WD_BASE_S = 40;
  localparam int TOPOFF_BASE_MIN = 15;
  localparam int SEC_PER_MIN = 60;
  localparam int PT_HI = 7;
  localparam int PT_LO = 4;
  localparam int TT_HI = 3;
  localparam int VC_HI = 7;
  localparam int VC_LO = 3;
  localparam int TO_HI = 2;
  localparam int TO_LO = 1;
  localparam int RCH_BIT = 0;
  localparam int TERM_EN_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int WD_HI = 5;
  localparam int WD_LO = 4;
  localparam int SAFE_EN_BIT = 3;
  localparam int FC_TMR_BIT = 2;
  localparam int THERM_BIT = 1;
  localparam int COLD_BIT = 0;
endpackage

/* watchdog_timer.sv */
`timescale 1ns/1ps
module watchdog_timer
  import charger_cfg_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = CLK_HZ * WD_BASE_S
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic kick_i,
  input wire logic [1:0] period_i,
  output logic expire_o
);
  logic [34:0] count_r;
  logic [34:0] limit;

  always_comb begin
    case (period_i)
      WD_40S: limit = 35'(BASE_CYCLES);
      WD_80S: limit = 35'(BASE_CYCLES) << 1;
      default: limit = 35'(BASE_CYCLES) << 2;
    endcase
  end

  // Kick or a disabled period holds the count at zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_r <= '0;
    end else if (kick_i || period_i == WD_OFF || expire_o) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + 35'd1;
    end
  end

  assign expire_o = (period_i != WD_OFF) && (count_r >= limit - 35'd1);
endmodule // watchdog_timer

/* charger_config_registers.sv */
`timescale 1ns/1ps
// What this block does
// - Precharge code bits 7:4, termination bits 3:0, both default 0010.
// - Precharge codes above 1100 act as 1100.
// - Charge voltage code bits 7:3, default 01011, 01111 special value.
// - Charge voltage writes above 11000 are stored as 11000.
// - Top-off select bits 2:1, default off, 15/30/45 minutes.
// - Top-off off means charging ends at once on termination.
// - Recharge threshold bit 0: 100 mV or 200 mV, default 100.
// - Termination enable bit 7 of timer register, default 1.
// - Watchdog period bits 5:4: off, 40, 80, 160 s; default 40 s.
// - Safety timer enable bit 3 gates both safety timers, default 1.
// - Fast-charge timer bit 2: 5 or 10 hours, default 10.
// - Thermal regulation bit 1: 90 or 110 C, default 110.
// - Cold-zone bit 0: 50% or 20% of fast charge, default 20%.
// - Register reset and watchdog expiry restore all three defaults.
// - Host kicks watchdog; device clears the kick bit afterwards.
module charger_config_registers
  import charger_cfg_pkg::*;
#(
  parameter int unsigned WD_BASE_CYCLES = CLK_HZ * WD_BASE_S,
  // 64-bit so the 15 minute base at full clock rate does not overflow
  parameter longint unsigned TOPOFF_BASE_CYCLES =
    longint'(CLK_HZ) * SEC_PER_MIN * TOPOFF_BASE_MIN
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic reg_reset_i,
  input wire logic watchdog_kick_bit_i,
  input wire logic term_condition_i,
  output logic watchdog_kick_bit_o,
  output logic watchdog_expired_o,
  output logic [3:0] precharge_current_code_o,
  output logic [3:0] termination_current_code_o,
  output logic [4:0] charge_voltage_code_o,
  output logic [1:0] topoff_extension_select_o,
  output logic recharge_threshold_select_o,
  output logic termination_enable_o,
  output logic [1:0] watchdog_period_o,
  output logic safety_timer_enable_o,
  output logic fast_charge_timer_select_o,
  output logic thermal_regulation_select_o,
  output logic cold_zone_current_select_o,
  output logic charge_done_o
);
  logic [7:0] prechg_term_r;
  logic [7:0] volt_topoff_r;
  logic [7:0] timer_ctrl_r;
  logic kick_r;
  logic wd_expire;
  logic restore;
  // 37 bits hold three base periods of 15 minutes at full clock rate
  logic [36:0] topoff_cnt_r;
  logic topoff_run_r;
  logic done_r;
  logic [36:0] topoff_limit;

  function automatic logic [4:0] clamp_volt(input logic [4:0] code);
    clamp_volt = (code > VOLT_MAX_CODE) ? VOLT_MAX_CODE : code;
  endfunction

  assign restore = reg_reset_i || wd_expire;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prechg_term_r <= RST_PRECHG_TERM;
    end else if (restore) begin
      prechg_term_r <= RST_PRECHG_TERM;
    end else if (wr_en_i && addr_i == ADDR_PRECHG_TERM) begin
      prechg_term_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      volt_topoff_r <= RST_VOLT_TOPOFF;
    end else if (restore) begin
      volt_topoff_r <= RST_VOLT_TOPOFF;
    end else if (wr_en_i && addr_i == ADDR_VOLT_TOPOFF) begin
      volt_topoff_r <= {clamp_volt(wdata_i[VC_HI:VC_LO]),
                        wdata_i[TO_HI:0]};
    end
  end

  // Reserved bit kept as written
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_ctrl_r <= RST_TIMER_CTRL;
    end else if (restore) begin
      timer_ctrl_r <= RST_TIMER_CTRL;
    end else if (wr_en_i && addr_i == ADDR_TIMER_CTRL) begin
      timer_ctrl_r <= wdata_i;
    end
  end

  // Kick bit reads 1 only until the counter has restarted
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      kick_r <= 1'b0;
    end else if (watchdog_kick_bit_i) begin
      kick_r <= 1'b1;
    end else begin
      kick_r <= 1'b0;
    end
  end

  watchdog_timer #(
    .BASE_CYCLES(WD_BASE_CYCLES)
  ) u_wd (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .kick_i(watchdog_kick_bit_i || reg_reset_i),
    .period_i(timer_ctrl_r[WD_HI:WD_LO]),
    .expire_o(wd_expire)
  );

  always_comb begin
    case (addr_i)
      ADDR_PRECHG_TERM: rdata_o = prechg_term_r;
      ADDR_VOLT_TOPOFF: rdata_o = volt_topoff_r;
      ADDR_TIMER_CTRL: rdata_o = timer_ctrl_r;
      default: rdata_o = 8'h00;
    endcase
  end

  // Analog side never sees a precharge code past the limit
  always_comb begin
    precharge_current_code_o = prechg_term_r[PT_HI:PT_LO];
    if (prechg_term_r[PT_HI:PT_LO] > PRECHG_MAX_CODE) begin
      precharge_current_code_o = PRECHG_MAX_CODE;
    end
  end

  assign termination_current_code_o = prechg_term_r[TT_HI:0];
  assign charge_voltage_code_o = volt_topoff_r[VC_HI:VC_LO];
  assign topoff_extension_select_o = volt_topoff_r[TO_HI:TO_LO];
  assign recharge_threshold_select_o = volt_topoff_r[RCH_BIT];
  assign termination_enable_o = timer_ctrl_r[TERM_EN_BIT];
  assign watchdog_period_o = timer_ctrl_r[WD_HI:WD_LO];
  assign safety_timer_enable_o = timer_ctrl_r[SAFE_EN_BIT];
  assign fast_charge_timer_select_o = timer_ctrl_r[FC_TMR_BIT];
  assign thermal_regulation_select_o = timer_ctrl_r[THERM_BIT];
  assign cold_zone_current_select_o = timer_ctrl_r[COLD_BIT];
  assign watchdog_kick_bit_o = kick_r;
  assign watchdog_expired_o = wd_expire;

  assign topoff_limit = 37'(TOPOFF_BASE_CYCLES) *
                        37'(topoff_extension_select_o);

  // Top-off extension after termination
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      topoff_run_r <= 1'b0;
      topoff_cnt_r <= '0;
      done_r <= 1'b0;
    end else if (!termination_enable_o || !term_condition_i) begin
      topoff_run_r <= 1'b0;
      topoff_cnt_r <= '0;
      done_r <= 1'b0;
    end else if (topoff_extension_select_o == TOPOFF_OFF) begin
      done_r <= 1'b1;
      topoff_run_r <= 1'b0;
    end else if (!done_r) begin
      topoff_run_r <= 1'b1;
      topoff_cnt_r <= topoff_cnt_r + 37'd1;
      if (topoff_cnt_r >= topoff_limit - 37'd1) begin
        done_r <= 1'b1;
        topoff_run_r <= 1'b0;
      end
    end
  end

  assign charge_done_o = done_r;
endmodule // charger_config_registers

/* charger_cfg_properties.sv */
`timescale 1ns/1ps
module charger_cfg_properties
  import charger_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic reg_reset_i,
  input wire logic watchdog_kick_bit_i,
  input wire logic term_condition_i,
  input wire logic watchdog_kick_bit_o,
  input wire logic watchdog_expired_o,
  input wire logic [3:0] precharge_current_code_o,
  input wire logic [4:0] charge_voltage_code_o,
  input wire logic [1:0] topoff_extension_select_o,
  input wire logic termination_enable_o,
  input wire logic [1:0] watchdog_period_o,
  input wire logic charge_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic ok;
  // Reset and expiry win over a same-cycle write
  assign ok = !reg_reset_i && !watchdog_expired_o;
  property p_volt; wr_en_i && ok && addr_i == ADDR_VOLT_TOPOFF &&
    wdata_i[7:3] > VOLT_MAX_CODE |=> charge_voltage_code_o == VOLT_MAX_CODE;
  endproperty
  a_volt: assert property (p_volt) else $error("volt clamp");
  property p_pre; addr_i == ADDR_PRECHG_TERM |-> precharge_current_code_o ==
    (rdata_o[7:4] > PRECHG_MAX_CODE ? PRECHG_MAX_CODE : rdata_o[7:4]);
  endproperty
  a_pre: assert property (p_pre) else $error("precharge clamp");
  property p_rst; reg_reset_i |=> {charge_voltage_code_o,
    topoff_extension_select_o, termination_enable_o} == 8'h59;
  endproperty
  a_rst: assert property (p_rst) else $error("reg reset");
  property p_wdx; watchdog_expired_o |=> precharge_current_code_o == 4'h2 &&
    watchdog_period_o == WD_40S; endproperty
  a_wdx: assert property (p_wdx) else $error("expiry reset");
  property p_kick; watchdog_kick_bit_i ##1 !watchdog_kick_bit_i |->
    watchdog_kick_bit_o ##1 !watchdog_kick_bit_o; endproperty
  a_kick: assert property (p_kick) else $error("kick bit");
  property p_quiet; watchdog_kick_bit_i |=> !watchdog_expired_o [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("early expiry");
  property p_off; watchdog_period_o == WD_OFF |-> !watchdog_expired_o;
  endproperty
  a_off: assert property (p_off) else $error("expiry when off");
  property p_done; term_condition_i && termination_enable_o && ok &&
    topoff_extension_select_o == TOPOFF_OFF |-> ##[1:2] charge_done_o;
  endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_noterm; $rose(charge_done_o) |-> $past(termination_enable_o);
  endproperty
  a_noterm: assert property (p_noterm) else $error("done unenabled");
endmodule // charger_cfg_properties

bind charger_config_registers charger_cfg_properties u_props (.*);

/* charger_config_registers_bench.sv */
`timescale 1ns/1ps
module charger_config_registers_bench;
  import charger_cfg_pkg::*;
  logic clk_i = 0, arst_n_i = 0, wr_en_i = 0, reg_reset_i = 0;
  logic watchdog_kick_bit_i = 0, term_condition_i = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic watchdog_kick_bit_o, watchdog_expired_o, recharge_threshold_select_o;
  logic termination_enable_o, safety_timer_enable_o, charge_done_o;
  logic fast_charge_timer_select_o, thermal_regulation_select_o;
  logic cold_zone_current_select_o;
  logic [3:0] precharge_current_code_o, termination_current_code_o;
  logic [4:0] charge_voltage_code_o;
  logic [1:0] topoff_extension_select_o, watchdog_period_o;
  int n_mismatch = 0, comparisons = 0, i;
  // Short watchdog base so expiry fits in the run
  charger_config_registers #(.WD_BASE_CYCLES(100), .TOPOFF_BASE_CYCLES(50))
    DUT (.*);
  always #12.5 clk_i = ~clk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    #1 check(rdata_o, exp);
  endtask
  task automatic defaults;
    rd(ADDR_PRECHG_TERM, RST_PRECHG_TERM);
    rd(ADDR_VOLT_TOPOFF, RST_VOLT_TOPOFF);
    rd(ADDR_TIMER_CTRL, RST_TIMER_CTRL);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    defaults();
    rd(8'h06, 8'h00);
    $display("defaults done");
    wr(ADDR_VOLT_TOPOFF, 8'h78);
    rd(ADDR_VOLT_TOPOFF, 8'h78);
    @(posedge clk_i);
    watchdog_kick_bit_i <= 1'b1;
    @(posedge clk_i);
    watchdog_kick_bit_i <= 1'b0;
    #1 check(8'(watchdog_kick_bit_o), 8'h01);
    i = 0;
    while (watchdog_expired_o !== 1'b1 && i < 300) begin
      @(posedge clk_i);
      #1 i++;
    end
    check(8'(i >= 95 && i <= 105), 8'h01);
    rd(ADDR_VOLT_TOPOFF, RST_VOLT_TOPOFF);
    $display("watchdog done");
    // Watchdog off from here so later checks are not wiped
    wr(ADDR_TIMER_CTRL, 8'h4F);
    rd(ADDR_TIMER_CTRL, 8'h4F);
    check(8'({termination_enable_o, watchdog_period_o, safety_timer_enable_o,
      fast_charge_timer_select_o, thermal_regulation_select_o,
      cold_zone_current_select_o}), 8'h0F);
    wr(ADDR_VOLT_TOPOFF, 8'hFF);
    wr(ADDR_PRECHG_TERM, 8'hF5);
    rd(ADDR_VOLT_TOPOFF, 8'hC7);
    check(8'({topoff_extension_select_o, recharge_threshold_select_o}),
      8'h07);
    rd(ADDR_PRECHG_TERM, 8'hF5);
    check(8'(precharge_current_code_o), 8'h0C);
    check(8'(termination_current_code_o), 8'h05);
    $display("fields done");
    @(posedge clk_i);
    term_condition_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(8'(charge_done_o), 8'h00);
    reg_reset_i <= 1'b1;
    @(posedge clk_i);
    reg_reset_i <= 1'b0;
    defaults();
    repeat (2) @(posedge clk_i);
    #1 check(8'(charge_done_o), 8'h01);
    $display("termination done");
    @(posedge clk_i);
    term_condition_i <= 1'b0;
    wr(ADDR_TIMER_CTRL, 8'h8F);
    wr(ADDR_VOLT_TOPOFF, 8'h5A);
    @(posedge clk_i);
    term_condition_i <= 1'b1;
    i = 0;
    while (charge_done_o !== 1'b1 && i < 100) begin
      @(posedge clk_i);
      #1 i++;
    end
    check(8'(i >= 48 && i <= 52), 8'h01);
    $display("topoff done");
    close_out();
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    n_mismatch++;
    $display("[FAIL] %0t watchdog limit reached", $time);
    close_out();
  end
endmodule // charger_config_registers_bench
